// ### upc_pkg.sv
// Constants, reset values and state types for the channel pin-control block.
// Assumes one 125 MHz system clock and a 16x oversampling baud tick.
package upc_pkg;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 4;
  localparam int CLK_PERIOD_NS = 8;
  localparam logic [3:0] BIT_LAST = 4'hF;
  localparam logic [3:0] HALF_LAST = 4'h7;
  localparam logic [3:0] IR_PULSE_TICKS = 4'h3;
  localparam logic [2:0] DATA_BIT_LAST = 3'h7;
  localparam logic [15:0] BAUD_ONE = 16'h0001;
  localparam logic TX_IDLE_LEVEL = 1'b1;
  localparam logic IRQ_OE_RST = 1'b0;
  localparam logic GP_OUT_RST = 1'b1;
  localparam logic PIN_N_RST = 1'b1;
  localparam logic [3:0] MODEM_SYNC_RST = 4'hF;
  localparam int MS_CTS = 0;
  localparam int MS_DSR = 1;
  localparam int MS_CD = 2;
  localparam int MS_RI = 3;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} upc_tx_st_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} upc_rx_st_t;
endpackage

// ### upc_fifo_if.sv
// Valid/ready carrier between the channel logic and its transmit FIFO.
// Assumes both sides sit on the same system clock.
`timescale 1ns/100ps
interface upc_fifo_if #(parameter int W = 8);
  logic wr_valid;
  logic wr_ready;
  logic [W-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [W-1:0] rd_data;
  modport fifo (input wr_valid, input wr_data, input rd_ready,
                output wr_ready, output rd_valid, output rd_data);
  modport fill (output wr_valid, output wr_data, input wr_ready);
  modport drain (input rd_valid, input rd_data, output rd_ready);
endinterface

// ### upc_fifo.sv
// Small synchronous FIFO with registered write-side ready.
// Assumes synchronous active-high reset and a power-of-two-free depth.
`timescale 1ns/100ps
module upc_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Both sides of the buffer
  upc_fifo_if.fifo bus
);
  localparam int PW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(D - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(D);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);

  logic [W-1:0] mem [D];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic ready_r;
  wire push = bus.wr_valid && ready_r;
  wire pop = bus.rd_valid && bus.rd_ready;

  ////////////////////////////////////////////////////////////////////////
  // Status and read data
  assign bus.wr_ready = ready_r;
  assign bus.rd_valid = (cnt_r != '0);
  assign bus.rd_data = mem[rd_ptr_r];
  assign cnt_nxt = push && !pop ? cnt_r + CNT_ONE : (pop && !push ? cnt_r - CNT_ONE : cnt_r);

  ////////////////////////////////////////////////////////////////////////
  // Ready is registered so the host sees it from a flop, full stays honest
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
      ready_r <= 1'b0;
    end else begin
      if (push) begin
        mem[wr_ptr_r] <= bus.wr_data;
        wr_ptr_r <= (wr_ptr_r == PTR_LAST) ? '0 : wr_ptr_r + PW'(1);
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == PTR_LAST) ? '0 : rd_ptr_r + PW'(1);
      end
      cnt_r <= cnt_nxt;
      ready_r <= (cnt_nxt != CNT_FULL);
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_fifo_no_over: assert property (cnt_r == CNT_FULL |-> !ready_r)
    else $error("fifo ready while full");
endmodule

// ### upc_chan.sv
// One UART channel: pin-level behaviour of interrupt, ready, serial and modem lines.
// Assumes control bits come from same-clock logic; serial and modem pins are asynchronous.
// Behaviour
// - Interrupt enable set: drive irq, gp low
// - Interrupt enable clear: irq tri-state, gp high
// - Active-low transmit ready shows FIFO status
// - Active-low receive ready shows holding status
// - Standard mode: serial out idles high
// - Infrared mode: encoder/decoder, output idles low
// - Optional receive inversion ahead of infrared decoder
// - Auto request-to-send needs software assertion first
// - Request-to-send gives RS485 direction control
// - Clear-to-send gates transmit; change can interrupt
// - Set-ready, carrier, ring are plain inputs
// - Terminal-ready output doubles as general output
`timescale 1ns/100ps
module upc_chan (
  // Clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_SYS_RST,
  // Host transmit and receive data
  input wire logic [7:0] I_TX_DATA,
  input wire logic I_TX_VALID,
  output logic O_TX_READY,
  output logic [7:0] O_RX_DATA,
  output logic O_RX_VALID,
  input wire logic I_RX_READ,
  input wire logic I_IRQ_REQ,
  input wire logic [15:0] I_BAUD_DIV,
  // Control bits
  input wire logic I_IRQ_PIN_OE,
  input wire logic I_IR_MODE,
  input wire logic I_SW_RTS,
  input wire logic I_SW_DTR,
  input wire logic I_IR_RX_INV,
  input wire logic I_RS485_FUNC,
  input wire logic I_RS485_MODE,
  input wire logic I_AUTO_RTS,
  input wire logic I_AUTO_CTS,
  input wire logic I_CTS_IRQ_EN,
  input wire logic I_CTS_CHG_CLR,
  // Status bits
  output logic O_CTS_CHG,
  output logic [3:0] O_MODEM_STAT,
  // Channel pins
  output logic O_CHAN_IRQ_OUT,
  output logic O_CHAN_IRQ_OE,
  output logic O_CHAN_GP_OUT_PORT,
  output logic O_CHAN_TX_READY_N,
  output logic O_CHAN_RX_READY_N,
  output logic O_CHAN_SERIAL_OUT,
  input wire logic I_CHAN_SERIAL_IN,
  output logic O_CHAN_REQUEST_SEND_N,
  input wire logic I_CHAN_CLEAR_SEND_N,
  output logic O_CHAN_TERMINAL_READY_N,
  input wire logic I_CHAN_SET_READY_N,
  input wire logic I_CHAN_CARRIER_DETECT_N,
  input wire logic I_CHAN_RING_INDICATOR_N
);

  // Compare a tick counter against its last value
  function automatic logic f_last(input logic [3:0] cnt, input logic [3:0] lim);
    f_last = (cnt == lim);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Transmit FIFO
  upc_fifo_if #(.W(upc_pkg::DATA_W)) fif ();
  upc_fifo #(.W(upc_pkg::DATA_W), .D(upc_pkg::FIFO_DEPTH)) u_tx_fifo (
    .i_clk(I_SYS_CLK),
    .i_rst(I_SYS_RST),
    .bus(fif.fifo)
  );
  assign fif.wr_valid = I_TX_VALID;
  assign fif.wr_data = I_TX_DATA;
  assign O_TX_READY = fif.wr_ready; // Flop inside the FIFO

  ////////////////////////////////////////////////////////////////////////
  // Baud tick, 16 per bit; divisor zero behaves as one
  logic [15:0] div_cnt_r;
  wire [15:0] div_last = (I_BAUD_DIV == '0) ? '0 : I_BAUD_DIV - upc_pkg::BAUD_ONE;
  wire tick = (div_cnt_r >= div_last);
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST || tick) begin
      div_cnt_r <= '0;
    end else begin
      div_cnt_r <= div_cnt_r + upc_pkg::BAUD_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers; first stage feeds only the second
  logic rx_s1_r;
  logic rx_s2_r;
  logic [3:0] ms_s1_r;
  logic [3:0] ms_s2_r;
  logic cts_d_r;
  wire [3:0] ms_pins = {I_CHAN_RING_INDICATOR_N, I_CHAN_CARRIER_DETECT_N,
                        I_CHAN_SET_READY_N, I_CHAN_CLEAR_SEND_N};
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      rx_s1_r <= upc_pkg::PIN_N_RST;
      rx_s2_r <= upc_pkg::PIN_N_RST;
      ms_s1_r <= upc_pkg::MODEM_SYNC_RST;
      ms_s2_r <= upc_pkg::MODEM_SYNC_RST;
      cts_d_r <= upc_pkg::PIN_N_RST;
    end else begin
      rx_s1_r <= I_CHAN_SERIAL_IN;
      rx_s2_r <= rx_s1_r;
      ms_s1_r <= ms_pins;
      ms_s2_r <= ms_s1_r;
      cts_d_r <= ms_s2_r[upc_pkg::MS_CTS];
    end
  end
  wire cts_n_s = ms_s2_r[upc_pkg::MS_CTS];
  wire cts_edge = cts_n_s ^ cts_d_r;

  ////////////////////////////////////////////////////////////////////////
  // Transmitter; clear-to-send only delays the next start, never cuts a byte
  upc_pkg::upc_tx_st_t tx_st_r;
  upc_pkg::upc_tx_st_t tx_st_nxt;
  logic [3:0] tx_tick_r;
  logic [2:0] tx_bit_r;
  logic [7:0] tx_sh_r;
  wire cts_ok = !(I_AUTO_CTS && cts_n_s);
  wire tx_start = (tx_st_r == upc_pkg::TX_IDLE) && fif.rd_valid && cts_ok;
  wire tx_bit_end = tick && f_last(tx_tick_r, upc_pkg::BIT_LAST);
  wire tx_busy = (tx_st_r != upc_pkg::TX_IDLE);
  assign fif.rd_ready = tx_start;

  always_comb begin
    tx_st_nxt = tx_st_r;
    case (tx_st_r)
      upc_pkg::TX_IDLE: if (tx_start) tx_st_nxt = upc_pkg::TX_START;
      upc_pkg::TX_START: if (tx_bit_end) tx_st_nxt = upc_pkg::TX_DATA;
      upc_pkg::TX_DATA: begin
        if (tx_bit_end && tx_bit_r == upc_pkg::DATA_BIT_LAST) tx_st_nxt = upc_pkg::TX_STOP;
      end
      upc_pkg::TX_STOP: if (tx_bit_end) tx_st_nxt = upc_pkg::TX_IDLE;
      default: tx_st_nxt = upc_pkg::TX_IDLE;
    endcase
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      tx_st_r <= upc_pkg::TX_IDLE;
      tx_tick_r <= '0;
      tx_bit_r <= '0;
      tx_sh_r <= '0;
    end else begin
      tx_st_r <= tx_st_nxt;
      if (tx_start) begin
        tx_sh_r <= fif.rd_data;
        tx_tick_r <= '0;
        tx_bit_r <= '0;
      end else if (tick && tx_busy) begin
        tx_tick_r <= tx_tick_r + 4'h1;
        if (tx_bit_end && tx_st_r == upc_pkg::TX_DATA) begin
          tx_sh_r <= {1'b0, tx_sh_r[7:1]};
          tx_bit_r <= tx_bit_r + 3'h1;
        end
      end
    end
  end

  // Line level: standard NRZ, or a 3/16 high pulse for each zero in infrared
  wire tx_bit = (tx_st_r == upc_pkg::TX_START) ? 1'b0 :
                (tx_st_r == upc_pkg::TX_DATA) ? tx_sh_r[0] : upc_pkg::TX_IDLE_LEVEL;
  wire ir_pulse = tx_busy && !tx_bit && (tx_tick_r < upc_pkg::IR_PULSE_TICKS);
  wire tx_out_nxt = I_IR_MODE ? ir_pulse : tx_bit;

  ////////////////////////////////////////////////////////////////////////
  // Receive front end: optional inversion, then infrared pulse stretch
  logic [3:0] ir_hold_r;
  wire rx_pol = rx_s2_r ^ (I_IR_MODE && I_IR_RX_INV);
  wire rx_ir_line = !(rx_pol || ir_hold_r != '0);
  wire rx_line = I_IR_MODE ? rx_ir_line : rx_pol;
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      ir_hold_r <= '0;
    end else if (rx_pol) begin
      ir_hold_r <= upc_pkg::BIT_LAST;
    end else if (tick && ir_hold_r != '0) begin
      ir_hold_r <= ir_hold_r - 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receiver; a new byte overwrites an unread one rather than stalling
  upc_pkg::upc_rx_st_t rx_st_r;
  upc_pkg::upc_rx_st_t rx_st_nxt;
  logic [3:0] rx_tick_r;
  logic [2:0] rx_bit_r;
  logic [7:0] rx_sh_r;
  logic rx_valid_r;
  logic [7:0] rx_data_r;
  wire rx_half = tick && f_last(rx_tick_r, upc_pkg::HALF_LAST);
  wire rx_bit_end = tick && f_last(rx_tick_r, upc_pkg::BIT_LAST);
  wire rx_store = (rx_st_r == upc_pkg::RX_STOP) && rx_bit_end && rx_line;
  wire rx_valid_nxt = rx_store || (rx_valid_r && !I_RX_READ); // Set wins over read

  always_comb begin
    rx_st_nxt = rx_st_r;
    case (rx_st_r)
      upc_pkg::RX_IDLE: if (!rx_line) rx_st_nxt = upc_pkg::RX_START;
      upc_pkg::RX_START: begin
        if (rx_half) rx_st_nxt = rx_line ? upc_pkg::RX_IDLE : upc_pkg::RX_DATA;
      end
      upc_pkg::RX_DATA: begin
        if (rx_bit_end && rx_bit_r == upc_pkg::DATA_BIT_LAST) rx_st_nxt = upc_pkg::RX_STOP;
      end
      upc_pkg::RX_STOP: if (rx_bit_end) rx_st_nxt = upc_pkg::RX_IDLE;
      default: rx_st_nxt = upc_pkg::RX_IDLE;
    endcase
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      rx_st_r <= upc_pkg::RX_IDLE;
      rx_tick_r <= '0;
      rx_bit_r <= '0;
      rx_sh_r <= '0;
      rx_data_r <= '0;
      rx_valid_r <= 1'b0;
    end else begin
      rx_st_r <= rx_st_nxt;
      rx_valid_r <= rx_valid_nxt;
      if (rx_store) rx_data_r <= rx_sh_r;
      if (rx_st_r == upc_pkg::RX_IDLE || rx_half && rx_st_r == upc_pkg::RX_START) begin
        rx_tick_r <= '0;
        rx_bit_r <= '0;
      end else if (tick) begin
        rx_tick_r <= rx_tick_r + 4'h1;
        if (rx_bit_end && rx_st_r == upc_pkg::RX_DATA) begin
          rx_sh_r <= {rx_line, rx_sh_r[7:1]};
          rx_bit_r <= rx_bit_r + 3'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Request-to-send: RS485 direction wins over auto flow, else software level
  wire rs485_en = I_RS485_FUNC && I_RS485_MODE;
  wire rts_n_nxt = rs485_en ? !tx_busy :
                   (!I_SW_RTS || (I_AUTO_RTS && rx_valid_nxt));
  wire cts_chg_nxt = (cts_edge && I_CTS_IRQ_EN) || (O_CTS_CHG && !I_CTS_CHG_CLR);

  ////////////////////////////////////////////////////////////////////////
  // Registered pins and status
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      O_CHAN_IRQ_OE <= upc_pkg::IRQ_OE_RST;
      O_CHAN_GP_OUT_PORT <= upc_pkg::GP_OUT_RST;
      O_CHAN_IRQ_OUT <= 1'b0;
      O_CHAN_TX_READY_N <= upc_pkg::PIN_N_RST;
      O_CHAN_RX_READY_N <= upc_pkg::PIN_N_RST;
      O_CHAN_SERIAL_OUT <= upc_pkg::TX_IDLE_LEVEL;
      O_CHAN_REQUEST_SEND_N <= upc_pkg::PIN_N_RST;
      O_CHAN_TERMINAL_READY_N <= upc_pkg::PIN_N_RST;
      O_CTS_CHG <= 1'b0;
      O_MODEM_STAT <= '0;
      O_RX_DATA <= '0;
      O_RX_VALID <= 1'b0;
    end else begin
      O_CHAN_IRQ_OE <= I_IRQ_PIN_OE;
      O_CHAN_GP_OUT_PORT <= !I_IRQ_PIN_OE;
      O_CHAN_IRQ_OUT <= I_IRQ_REQ || O_CTS_CHG;
      O_CHAN_TX_READY_N <= !fif.wr_ready;
      O_CHAN_RX_READY_N <= !rx_valid_nxt;
      O_CHAN_SERIAL_OUT <= tx_out_nxt;
      O_CHAN_REQUEST_SEND_N <= rts_n_nxt;
      O_CHAN_TERMINAL_READY_N <= !I_SW_DTR;
      O_CTS_CHG <= cts_chg_nxt;
      O_MODEM_STAT <= ~ms_s2_r; // Status only, no path into tx or rx
      O_RX_DATA <= rx_store ? rx_sh_r : rx_data_r;
      O_RX_VALID <= rx_valid_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SYS_RST);

  a_irq_drive_on: assert property (
    I_IRQ_PIN_OE |=> O_CHAN_IRQ_OE && !O_CHAN_GP_OUT_PORT)
    else $error("irq not driven with enable set");
  a_irq_tristate_off: assert property (
    !I_IRQ_PIN_OE |=> !O_CHAN_IRQ_OE && O_CHAN_GP_OUT_PORT)
    else $error("irq not released with enable clear");
  a_tx_ready_pin: assert property (##1 O_CHAN_TX_READY_N == !$past(O_TX_READY))
    else $error("tx ready pin does not track fifo space");
  a_rx_ready_pin: assert property (O_RX_VALID == !O_CHAN_RX_READY_N)
    else $error("rx ready pin does not track holding status");
  a_std_idle_high: assert property ((!tx_busy && !I_IR_MODE) |=> O_CHAN_SERIAL_OUT)
    else $error("standard serial out not high when idle");
  a_ir_idle_low: assert property ((!tx_busy && I_IR_MODE) |=> !O_CHAN_SERIAL_OUT)
    else $error("infrared serial out not low when idle");
  a_ir_pulse_decode: assert property ((I_IR_MODE && rx_pol) ##1 I_IR_MODE |-> !rx_line)
    else $error("infrared pulse not decoded as zero");
  a_std_no_invert: assert property (!I_IR_MODE |-> rx_line == rx_s2_r)
    else $error("receive inversion active in standard mode");
  a_auto_rts_hold: assert property (
    (!rs485_en && I_AUTO_RTS && rx_valid_nxt) |=> O_CHAN_REQUEST_SEND_N)
    else $error("auto rts asserted while receive full");
  a_rts_soft_level: assert property (
    (!rs485_en && !I_AUTO_RTS) |=> O_CHAN_REQUEST_SEND_N == !$past(I_SW_RTS))
    else $error("rts pin does not follow software level");
  a_rs485_direction: assert property ((rs485_en && tx_busy) |=> !O_CHAN_REQUEST_SEND_N)
    else $error("rts not asserted during rs485 transmit");
  a_rs485_idle_off: assert property ((rs485_en && !tx_busy) |=> O_CHAN_REQUEST_SEND_N)
    else $error("rts asserted while rs485 transmitter idle");
  a_cts_gate_start: assert property (
    (I_AUTO_CTS && cts_n_s && !tx_busy) |=> tx_st_r == upc_pkg::TX_IDLE)
    else $error("transmit started with cts deasserted");
  a_cts_change_flag: assert property ((cts_edge && I_CTS_IRQ_EN) |=> O_CTS_CHG)
    else $error("cts change not flagged");
  // Sticky flag: only the clear pulse may drop it, and nothing sets it while reporting is off
  a_cts_flag_hold: assert property ((O_CTS_CHG && !I_CTS_CHG_CLR) |=> O_CTS_CHG)
    else $error("cts change flag lost without clear");
  a_cts_flag_quiet: assert property ((!I_CTS_IRQ_EN && !O_CTS_CHG) |=> !O_CTS_CHG)
    else $error("cts change flagged while reporting disabled");
  a_dtr_follow: assert property (##1 O_CHAN_TERMINAL_READY_N == !$past(I_SW_DTR))
    else $error("dtr pin does not follow control bit");

  // Modem status paths: two sync flops, then one status flop, for every pin
  a_dsr_sync_lat: assert property (
    ##3 O_MODEM_STAT[upc_pkg::MS_DSR] == !$past(I_CHAN_SET_READY_N, 3))
    else $error("set-ready status latency wrong");
  a_cts_sync_lat: assert property (
    ##3 O_MODEM_STAT[upc_pkg::MS_CTS] == !$past(I_CHAN_CLEAR_SEND_N, 3))
    else $error("clear-to-send status latency wrong");
  a_cd_sync_lat: assert property (
    ##3 O_MODEM_STAT[upc_pkg::MS_CD] == !$past(I_CHAN_CARRIER_DETECT_N, 3))
    else $error("carrier status latency wrong");
  a_ri_sync_lat: assert property (
    ##3 O_MODEM_STAT[upc_pkg::MS_RI] == !$past(I_CHAN_RING_INDICATOR_N, 3))
    else $error("ring status latency wrong");
endmodule

// ### upc_line_model.sv
// Far-side serial line model: sends frames into the channel and decodes its output.
// Assumes 16 system clocks per bit (baud divider of one) on the channel's clock.
`timescale 1ns/100ps
module upc_line_model (
  // Clock
  input wire logic i_clk,
  // Line pins
  input wire logic i_pin,
  output logic o_line
);
  ////////////////////////////////////////
  // Standard line rests high, as a pulled-up wire would
  initial o_line = 1'b1;

  // Idle level for the mode; infrared rests low unless inverted
  task automatic rest(input bit ir, input bit inv);
    @(posedge i_clk);
    o_line <= ir ? inv : 1'b1;
  endtask

  // Start, eight bits LSB first, stop; an infrared zero is a 3-tick pulse
  task automatic send(input bit ir, input bit inv, input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      for (int t = 0; t < 16; t++) begin
        @(posedge i_clk);
        if (ir) o_line <= inv ^ (!f[i] && t < 3);
        else o_line <= f[i];
      end
    end
    rest(ir, inv);
  endtask

  ////////////////////////////////////////
  // Decode one frame; sampled on the falling edge to stay clear of output updates
  task automatic recv(input bit ir, output logic [7:0] b, output bit ok);
    int n;
    n = 0;
    ok = 1'b0;
    b = 8'h00;
    while (i_pin !== ir && n < 4000) begin
      @(negedge i_clk);
      n++;
    end
    if (n < 4000) begin
      repeat (ir ? 1 : 8) @(negedge i_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (16) @(negedge i_clk);
        b[i] = ir ? !i_pin : i_pin;
      end
      repeat (16) @(negedge i_clk);
      ok = ir ? !i_pin : i_pin;
    end
  endtask
endmodule

// ### tb_upc_chan.sv
// Self-checking bench for one channel: pins, framing, flow control and modem lines.
// Assumes the line model from upc_line_model.sv and a baud divider of one.
`timescale 1ns/100ps
module tb_upc_chan;
  // Stimulus and observed signals
  logic clk = 1'b0, rst = 1'b1, tx_valid = 1'b0, rx_read = 1'b0, irq_req = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic [15:0] baud = 16'h0001;
  logic irq_oe = 1'b0, ir_mode = 1'b0, rts = 1'b0, dtr = 1'b0, rx_inv = 1'b0;
  logic f485 = 1'b0, e485 = 1'b0, a_rts = 1'b0, a_cts = 1'b0, cts_ie = 1'b0, chg_clr = 1'b0;
  logic cts_n = 1'b1, dsr_n = 1'b1, cd_n = 1'b1, ri_n = 1'b1;
  logic tx_ready, rx_valid, cts_chg, irq_out, irq_en, gp_out, txr_n, rxr_n, ser_out, line;
  logic rts_n, dtr_n;
  logic [7:0] rx_data;
  logic [3:0] mstat;
  int n_fail = 0;
  int cmp_count = 0;
  wire [7:0] pins = {irq_en, gp_out, ser_out, txr_n, rxr_n, rts_n, dtr_n, tx_ready};

  ////////////////////////////////////////
  // Clock
  always #(upc_pkg::CLK_PERIOD_NS / 2) clk = ~clk;

  // Block and far side
  upc_chan u_upc_chan (
    .I_SYS_CLK(clk), .I_SYS_RST(rst), .I_TX_DATA(tx_data), .I_TX_VALID(tx_valid),
    .O_TX_READY(tx_ready), .O_RX_DATA(rx_data), .O_RX_VALID(rx_valid), .I_RX_READ(rx_read),
    .I_IRQ_REQ(irq_req), .I_BAUD_DIV(baud), .I_IRQ_PIN_OE(irq_oe), .I_IR_MODE(ir_mode),
    .I_SW_RTS(rts), .I_SW_DTR(dtr), .I_IR_RX_INV(rx_inv), .I_RS485_FUNC(f485),
    .I_RS485_MODE(e485), .I_AUTO_RTS(a_rts), .I_AUTO_CTS(a_cts),
    .I_CTS_IRQ_EN(cts_ie), .I_CTS_CHG_CLR(chg_clr), .O_CTS_CHG(cts_chg), .O_MODEM_STAT(mstat),
    .O_CHAN_IRQ_OUT(irq_out), .O_CHAN_IRQ_OE(irq_en), .O_CHAN_GP_OUT_PORT(gp_out),
    .O_CHAN_TX_READY_N(txr_n), .O_CHAN_RX_READY_N(rxr_n), .O_CHAN_SERIAL_OUT(ser_out),
    .I_CHAN_SERIAL_IN(line), .O_CHAN_REQUEST_SEND_N(rts_n), .I_CHAN_CLEAR_SEND_N(cts_n),
    .O_CHAN_TERMINAL_READY_N(dtr_n), .I_CHAN_SET_READY_N(dsr_n),
    .I_CHAN_CARRIER_DETECT_N(cd_n), .I_CHAN_RING_INDICATOR_N(ri_n)
  );
  upc_line_model u_upc_line_model (.i_clk(clk), .i_pin(ser_out), .o_line(line));

  ////////////////////////////////////////
  // Shared helpers
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Offer a byte and hold it until the buffer shows room on a settled edge
  task automatic put(input logic [7:0] b);
    int n;
    n = 0;
    @(posedge clk);
    tx_valid <= 1'b1;
    tx_data <= b;
    @(negedge clk);
    while (tx_ready !== 1'b1 && n < 500) begin
      @(negedge clk);
      n++;
    end
    if (n == 500) begin
      n_fail++;
      summarize();
    end
    @(posedge clk);
    tx_valid <= 1'b0;
  endtask

  task automatic wait_rx();
    int n;
    n = 0;
    while (rx_valid !== 1'b1 && n < 500) begin
      @(negedge clk);
      n++;
    end
    if (n == 500) begin
      n_fail++;
      summarize();
    end
  endtask

  task automatic rd();
    @(posedge clk);
    rx_read <= 1'b1;
    @(posedge clk);
    rx_read <= 1'b0;
  endtask

  ////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    cyc(2);
    chk("reset pins", pins, 8'h7E);
    @(posedge clk);
    rst <= 1'b0;
    cyc(4);
    chk("idle pins", pins, 8'h6F);
    $display("reset test done");
  endtask

  task automatic t_irq();
    @(posedge clk);
    irq_oe <= 1'b1;
    irq_req <= 1'b1;
    dtr <= 1'b1;
    cyc(2);
    chk("irq on", {4'h0, irq_en, gp_out, irq_out, dtr_n}, 8'h0A);
    @(posedge clk);
    irq_oe <= 1'b0;
    irq_req <= 1'b0;
    dtr <= 1'b0;
    cyc(2);
    chk("irq off", {4'h0, irq_en, gp_out, irq_out, dtr_n}, 8'h05);
    $display("irq test done");
  endtask

  // Fill the buffer while clear-to-send is withheld, then let it drain
  task automatic t_tx();
    logic [7:0] q [4];
    logic [7:0] b;
    bit ok;
    q = '{8'h81, 8'h42, 8'hFF, 8'h00};
    @(posedge clk);
    a_cts <= 1'b1;
    cts_ie <= 1'b1;
    f485 <= 1'b1;
    e485 <= 1'b1;
    for (int i = 0; i < 4; i++) put(q[i]);
    cyc(3);
    chk("full", {6'h00, tx_ready, txr_n}, 8'h01);
    chk("stalled", {6'h00, ser_out, rts_n}, 8'h03);
    @(posedge clk);
    cts_n <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      u_upc_line_model.recv(1'b0, b, ok);
      chk("tx byte", b, q[i]);
      chk("tx stop", {7'h00, ok}, 8'h01);
      chk("direction", {7'h00, rts_n}, 8'h00);
      if (!ok) summarize(); // Line stuck or frame broken: stop here
    end
    cyc(20);
    chk("drained", {2'h0, tx_ready, txr_n, ser_out, rts_n, cts_chg, irq_out}, 8'h2F);
    @(posedge clk);
    chg_clr <= 1'b1;
    f485 <= 1'b0;
    e485 <= 1'b0;
    @(posedge clk);
    chg_clr <= 1'b0;
    cyc(2);
    chk("chg clear", {6'h00, cts_chg, irq_out}, 8'h00);
    $display("transmit test done");
  endtask

  // Receive with modem inputs asserted; auto request-to-send follows the held byte
  task automatic t_rx();
    @(posedge clk);
    rts <= 1'b1;
    a_rts <= 1'b1;
    dsr_n <= 1'b0;
    cd_n <= 1'b0;
    ri_n <= 1'b0;
    u_upc_line_model.send(1'b0, 1'b0, 8'hA5);
    wait_rx();
    cyc(2);
    chk("rx byte", rx_data, 8'hA5);
    chk("rx held", {5'h00, rxr_n, rts_n, rx_valid}, 8'h03);
    chk("modem", {4'h0, mstat}, 8'h0F);
    rd();
    cyc(2);
    chk("rx read", {5'h00, rxr_n, rts_n, rx_valid}, 8'h04);
    @(posedge clk);
    ri_n <= 1'b1;
    cyc(2);
    chk("sync delay", {4'h0, mstat}, 8'h0F);
    cyc(2);
    chk("sync done", {4'h0, mstat}, 8'h07);
    $display("receive test done");
  endtask

  // Infrared: output rests low, and receive works plain and inverted
  task automatic t_ir();
    logic [7:0] b;
    bit ok;
    @(posedge clk);
    ir_mode <= 1'b1;
    u_upc_line_model.rest(1'b1, 1'b0);
    cyc(200);
    chk("ir idle", {7'h00, ser_out}, 8'h00);
    rd();
    put(8'h96);
    u_upc_line_model.recv(1'b1, b, ok);
    chk("ir tx", b, 8'h96);
    chk("ir stop", {7'h00, ok}, 8'h01);
    if (!ok) summarize();
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      rx_inv <= k[0];
      u_upc_line_model.rest(1'b1, k[0]);
      cyc(200);
      rd();
      u_upc_line_model.send(1'b1, k[0], k[0] ? 8'h3C : 8'hC3);
      wait_rx();
      chk("ir rx", rx_data, k[0] ? 8'h3C : 8'hC3);
      rd();
    end
    $display("infrared test done");
  endtask

  ////////////////////////////////////////
  // Main sequence
  initial begin
    t_reset();
    t_irq();
    t_tx();
    t_rx();
    t_ir();
    summarize();
  end
endmodule
